// *** design/fpe_pkg.sv ***
// Package for the flash program/erase command sequencer
package fpe_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int BUF_DEPTH = 6;
    localparam int IDX_W = 3;
    // Register offsets
    localparam logic [7:0] OFS_STAT = 8'h00;
    localparam logic [7:0] OFS_IDX = 8'h04;
    localparam logic [7:0] OFS_BUF = 8'h08;
    localparam logic [7:0] OFS_PROT = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_SEC = 8'h14;
    // Status bit positions
    localparam int STAT_CCF = 7;
    localparam int STAT_ACC = 5;
    localparam int STAT_PV = 4;
    localparam int STAT_MG1 = 1;
    localparam int STAT_MG0 = 0;
    // Protection bit positions
    localparam int PROT_PLO = 0;
    localparam int PROT_PHI = 1;
    localparam int PROT_D = 2;
    localparam int SECTOR_HALF_BIT = 15;
    // Command codes
    localparam logic [7:0] CMD_ONCE = 8'h07;
    localparam logic [7:0] CMD_EALL = 8'h08;
    localparam logic [7:0] CMD_EBLK = 8'h09;
    localparam logic [7:0] CMD_ESEC = 8'h0A;
    localparam logic [7:0] CMD_UNSEC = 8'h0B;
    // Buffer index expected at launch
    localparam logic [2:0] IDX_ONCE = 3'h5;
    localparam logic [2:0] IDX_ALL = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [15:0] ONCE_MAX = 16'h0007;
    // Block select codes for address bits 17:16
    localparam logic [1:0] BSEL_PF = 2'h3;
    localparam logic [1:0] BSEL_DF = 2'h1;
    localparam logic [4:0] MODE_RST = 5'h1F;
    localparam logic SEC_RST = 1'b1;
    typedef enum logic [2:0] {
        FOP_BLANK, FOP_PROG, FOP_ERASE_ALL, FOP_ERASE_BLK, FOP_ERASE_SEC, FOP_VERIFY
    } fpe_op_t;
endpackage

// *** design/fpe_ctrl.sv ***
// Flash program/erase command sequencer with its register port
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fpe_ctrl (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    input wire logic [fpe_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [fpe_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [fpe_pkg::DATA_W-1:0] O_RDATA,
    output logic O_FL_REQ,
    output logic [2:0] O_FL_OP,
    output logic [1:0] O_FL_BSEL,
    output logic [15:0] O_FL_ADDR,
    output logic [63:0] O_FL_DATA,
    input wire logic I_FL_DONE,
    input wire logic I_FL_ERR,
    input wire logic I_FL_NCERR,
    output logic O_PF_READ_INVALID,
    output logic O_SECURE,
    output logic O_CCF
);
    import fpe_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_BLANK, S_PROG, S_VERIFY, S_DONE} fpe_state_t;

    fpe_state_t state_ff;
    fpe_state_t nxt_state;
    logic [DATA_W-1:0] cmd_param_buffer [BUF_DEPTH];
    logic [IDX_W-1:0] cmd_buffer_index_ff;
    logic command_complete_flag_ff;
    logic access_error_flag_ff;
    logic protection_violation_flag_ff;
    logic verify_status_1_ff;
    logic verify_status_0_ff;
    logic [2:0] prot_ff;
    logic [4:0] mode_ff;
    logic secure_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic fl_req_ff;
    fpe_op_t fl_op_ff;
    logic [1:0] fl_bsel_ff;
    logic [15:0] fl_addr_ff;
    logic [63:0] fl_data_ff;
    logic pf_invalid_ff;
    logic chk_acc;
    logic chk_pv;
    logic wr_ok;
    logic launch;
    logic issue;
    fpe_op_t issue_op;
    logic [7:0] cmd;
    logic [1:0] bsel;
    logic [15:0] paddr;
    function automatic logic mode_bit(input logic [4:0] m, input logic [7:0] c);
        logic [7:0] k;
        k = c - CMD_ONCE;
        mode_bit = (c >= CMD_ONCE && c <= CMD_UNSEC) ? m[k[2:0]] : 1'b0;
    endfunction
    assign cmd = cmd_param_buffer[0][15:8];
    assign bsel = cmd_param_buffer[0][1:0];
    assign paddr = cmd_param_buffer[1];
    // Writes ignored while a command runs
    assign wr_ok = I_WR && command_complete_flag_ff;
    assign launch = wr_ok && I_ADDR == OFS_STAT && I_WDATA[STAT_CCF]
        && (!access_error_flag_ff || I_WDATA[STAT_ACC])
        && (!protection_violation_flag_ff || I_WDATA[STAT_PV]);

    ////////////////////////////////////////////////////////////////////////
    // Launch-time parameter checks
    always_comb begin
        chk_acc = !mode_bit(mode_ff, cmd);
        chk_pv = 1'b0;
        case (cmd)
            CMD_ONCE: begin
                chk_acc = chk_acc || cmd_buffer_index_ff != IDX_ONCE;
                chk_acc = chk_acc || paddr > ONCE_MAX;
            end
            CMD_EALL, CMD_UNSEC: begin
                chk_acc = chk_acc || cmd_buffer_index_ff != IDX_ALL;
                chk_pv = |prot_ff;
            end
            CMD_EBLK: begin
                chk_acc = chk_acc || cmd_buffer_index_ff != IDX_ADDR;
                chk_acc = chk_acc || (bsel != BSEL_PF && bsel != BSEL_DF);
                chk_acc = chk_acc || (bsel == BSEL_PF && paddr[2:0] != 3'h0);
                chk_acc = chk_acc || (bsel == BSEL_DF && paddr[0]);
                chk_pv = (bsel == BSEL_PF) ? (prot_ff[PROT_PLO] | prot_ff[PROT_PHI])
                    : prot_ff[PROT_D];
            end
            CMD_ESEC: begin
                chk_acc = chk_acc || cmd_buffer_index_ff != IDX_ADDR;
                chk_acc = chk_acc || bsel != BSEL_PF || paddr[2:0] != 3'h0;
                chk_pv = paddr[SECTOR_HALF_BIT] ? prot_ff[PROT_PHI] : prot_ff[PROT_PLO];
            end
            default: chk_acc = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        issue = 1'b0;
        issue_op = FOP_VERIFY;
        case (state_ff)
            S_IDLE: begin
                if (launch) begin
                    nxt_state = S_CHECK;
                end
            end
            S_CHECK: begin
                if (chk_acc || chk_pv) begin
                    nxt_state = S_DONE;
                end else if (cmd == CMD_ONCE) begin
                    nxt_state = S_BLANK;
                    issue = 1'b1;
                    issue_op = FOP_BLANK;
                end else begin
                    nxt_state = S_PROG;
                    issue = 1'b1;
                    case (cmd)
                        CMD_EBLK: issue_op = FOP_ERASE_BLK;
                        CMD_ESEC: issue_op = FOP_ERASE_SEC;
                        default: issue_op = FOP_ERASE_ALL;
                    endcase
                end
            end
            S_BLANK: begin
                if (I_FL_DONE) begin
                    if (I_FL_ERR) begin
                        nxt_state = S_DONE;
                    end else begin
                        nxt_state = S_PROG;
                        issue = 1'b1;
                        issue_op = FOP_PROG;
                    end
                end
            end
            S_PROG: begin
                if (I_FL_DONE) begin
                    nxt_state = S_VERIFY;
                    issue = 1'b1;
                    issue_op = FOP_VERIFY;
                end
            end
            S_VERIFY: begin
                if (I_FL_DONE) begin
                    nxt_state = S_DONE;
                end
            end
            S_DONE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_ff <= S_IDLE;
        end else if (I_CE) begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash macro request
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            fl_req_ff <= 1'b0;
            fl_op_ff <= FOP_BLANK;
            fl_bsel_ff <= 2'h0;
            fl_addr_ff <= 16'h0000;
            fl_data_ff <= 64'h0000_0000_0000_0000;
        end else if (I_CE) begin
            fl_req_ff <= issue;
            if (issue) begin
                fl_op_ff <= issue_op;
                fl_bsel_ff <= bsel;
                fl_addr_ff <= paddr;
                fl_data_ff <= {cmd_param_buffer[5], cmd_param_buffer[4],
                               cmd_param_buffer[3], cmd_param_buffer[2]};
            end
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pf_invalid_ff <= 1'b0;
        end else if (I_CE) begin
            pf_invalid_ff <= nxt_state != S_IDLE && nxt_state != S_CHECK
                && cmd == CMD_ONCE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            command_complete_flag_ff <= 1'b1;
        end else if (I_CE) begin
            if (launch) begin
                command_complete_flag_ff <= 1'b0;
            end else if (state_ff == S_DONE) begin
                command_complete_flag_ff <= 1'b1;
            end
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            access_error_flag_ff <= 1'b0;
        end else if (I_CE) begin
            if (wr_ok && I_ADDR == OFS_STAT && I_WDATA[STAT_ACC]) begin
                access_error_flag_ff <= 1'b0;
            end
            if ((state_ff == S_CHECK && chk_acc) ||
                (state_ff == S_BLANK && I_FL_DONE && I_FL_ERR)) begin
                access_error_flag_ff <= 1'b1;
            end
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            protection_violation_flag_ff <= 1'b0;
        end else if (I_CE) begin
            if (wr_ok && I_ADDR == OFS_STAT && I_WDATA[STAT_PV]) begin
                protection_violation_flag_ff <= 1'b0;
            end
            if (state_ff == S_CHECK && !chk_acc && chk_pv) begin
                protection_violation_flag_ff <= 1'b1;
            end
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            verify_status_1_ff <= 1'b0;
            verify_status_0_ff <= 1'b0;
        end else if (I_CE) begin
            if (launch) begin
                verify_status_1_ff <= 1'b0;
                verify_status_0_ff <= 1'b0;
            end else if (state_ff == S_VERIFY && I_FL_DONE) begin
                verify_status_1_ff <= I_FL_ERR || I_FL_NCERR;
                verify_status_0_ff <= I_FL_NCERR;
            end
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            secure_ff <= SEC_RST;
        end else if (I_CE) begin
            if (state_ff == S_VERIFY && I_FL_DONE && !I_FL_ERR && !I_FL_NCERR
                && (cmd == CMD_EALL || cmd == CMD_UNSEC)) begin
                secure_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cmd_buffer_index_ff <= 3'h0;
            prot_ff <= 3'h0;
            mode_ff <= MODE_RST;
        end else if (I_CE && wr_ok) begin
            case (I_ADDR)
                OFS_IDX: cmd_buffer_index_ff <= I_WDATA[IDX_W-1:0];
                OFS_PROT: prot_ff <= I_WDATA[2:0];
                OFS_MODE: mode_ff <= I_WDATA[4:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                cmd_param_buffer[i] <= 16'h0000;
            end
        end else if (I_CE && wr_ok && I_ADDR == OFS_BUF
                     && cmd_buffer_index_ff < 3'(BUF_DEPTH)) begin
            cmd_param_buffer[cmd_buffer_index_ff] <= I_WDATA;
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_ff <= 16'h0000;
        end else if (I_CE) begin
            rdata_ff <= 16'h0000;
            if (I_RD) begin
                case (I_ADDR)
                    OFS_STAT: begin
                        rdata_ff[STAT_CCF] <= command_complete_flag_ff;
                        rdata_ff[STAT_ACC] <= access_error_flag_ff;
                        rdata_ff[STAT_PV] <= protection_violation_flag_ff;
                        rdata_ff[STAT_MG1] <= verify_status_1_ff;
                        rdata_ff[STAT_MG0] <= verify_status_0_ff;
                    end
                    OFS_IDX: rdata_ff[IDX_W-1:0] <= cmd_buffer_index_ff;
                    OFS_BUF: begin
                        if (cmd_buffer_index_ff < 3'(BUF_DEPTH)) begin
                            rdata_ff <= cmd_param_buffer[cmd_buffer_index_ff];
                        end
                    end
                    OFS_PROT: rdata_ff[2:0] <= prot_ff;
                    OFS_MODE: rdata_ff[4:0] <= mode_ff;
                    OFS_SEC: rdata_ff[0] <= secure_ff;
                    default: ;
                endcase
            end
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_FL_REQ = fl_req_ff;
    assign O_FL_OP = fl_op_ff;
    assign O_FL_BSEL = fl_bsel_ff;
    assign O_FL_ADDR = fl_addr_ff;
    assign O_FL_DATA = fl_data_ff;
    assign O_PF_READ_INVALID = pf_invalid_ff;
    assign O_SECURE = secure_ff;
    assign O_CCF = command_complete_flag_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ccf_low_busy;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (state_ff == S_BLANK || state_ff == S_PROG || state_ff == S_VERIFY)
            |-> !command_complete_flag_ff;
    endproperty
    a_ccf_low_busy: assert property (p_ccf_low_busy) else $error("flag high while busy");
    property p_launch;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && launch |=> !command_complete_flag_ff && state_ff == S_CHECK;
    endproperty
    a_launch: assert property (p_launch) else $error("launch not taken");
    property p_once_idx;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_CHECK && cmd == CMD_ONCE && cmd_buffer_index_ff != IDX_ONCE
            |=> access_error_flag_ff && state_ff == S_DONE;
    endproperty
    a_once_idx: assert property (p_once_idx) else $error("bad index not flagged");
    property p_once_range;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_CHECK && cmd == CMD_ONCE && paddr > ONCE_MAX
            |=> access_error_flag_ff;
    endproperty
    a_once_range: assert property (p_once_range) else $error("bad phrase not flagged");
    property p_not_blank;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_BLANK && I_FL_DONE && I_FL_ERR
            |=> access_error_flag_ff && !fl_req_ff;
    endproperty
    a_not_blank: assert property (p_not_blank) else $error("reprogram not refused");
    property p_no_op_on_err;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_CHECK && (chk_acc || chk_pv)
            |=> !fl_req_ff ##1 (command_complete_flag_ff || !$past(I_CE));
    endproperty
    a_no_op_on_err: assert property (p_no_op_on_err) else $error("op after failed check");
    property p_prot_all;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_CHECK && (cmd == CMD_EALL || cmd == CMD_UNSEC)
            && !chk_acc && |prot_ff |=> protection_violation_flag_ff;
    endproperty
    a_prot_all: assert property (p_prot_all) else $error("protection not flagged");
    property p_sec_kept;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        I_CE && state_ff == S_VERIFY && I_FL_DONE && I_FL_ERR
            |=> verify_status_1_ff && $stable(secure_ff);
    endproperty
    a_sec_kept: assert property (p_sec_kept) else $error("security changed on fail");
    property p_once_invalid;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        state_ff == S_PROG && cmd == CMD_ONCE |-> O_PF_READ_INVALID;
    endproperty
    a_once_invalid: assert property (p_once_invalid) else $error("read guard missing");
endmodule // fpe_ctrl

// *** tb/tb_top.sv ***
// Self-checking bench for the flash program/erase command sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import fpe_pkg::*;
    logic mclk;
    logic reset_n;
    logic wr;
    logic rd;
    logic fl_done;
    logic fl_err;
    logic fl_ncerr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic fl_req;
    logic [2:0] fl_op;
    logic [1:0] fl_bsel;
    logic [15:0] fl_addr;
    logic [63:0] fl_data;
    logic pf_inv;
    logic secure;
    logic ccf;
    logic ce;
    logic exp_sec;
    logic [15:0] bw [6];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    fpe_ctrl i_fpe_ctrl (
        .I_MCLK(mclk),
        .I_RESET_N(reset_n),
        .I_CE(ce),
        .I_ADDR(addr),
        .I_WDATA(wdata),
        .I_WR(wr),
        .I_RD(rd),
        .O_RDATA(rdata),
        .O_FL_REQ(fl_req),
        .O_FL_OP(fl_op),
        .O_FL_BSEL(fl_bsel),
        .O_FL_ADDR(fl_addr),
        .O_FL_DATA(fl_data),
        .I_FL_DONE(fl_done),
        .I_FL_ERR(fl_err),
        .I_FL_NCERR(fl_ncerr),
        .O_PF_READ_INVALID(pf_inv),
        .O_SECURE(secure),
        .O_CCF(ccf)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic f_acc(input logic [7:0] c, input logic [2:0] ix,
            input logic [1:0] bs, input logic [15:0] ad, input logic [4:0] md);
        if (!md[3'(c - CMD_ONCE)]) return 1'b1;
        case (c)
            CMD_ONCE: return ix != 3'h5 || ad > 16'h0007;
            CMD_EBLK: return ix != 3'h1 || !((bs == BSEL_PF && ad[2:0] == 3'h0) ||
                (bs == BSEL_DF && !ad[0]));
            CMD_ESEC: return ix != 3'h1 || bs != BSEL_PF || ad[2:0] != 3'h0;
            default: return ix != 3'h0;
        endcase
    endfunction

    function automatic logic f_pv(input logic [7:0] c, input logic [1:0] bs,
            input logic [15:0] ad, input logic [2:0] pr);
        case (c)
            CMD_EBLK: return bs == BSEL_PF ? pr[PROT_PLO] | pr[PROT_PHI] : pr[PROT_D];
            CMD_ESEC: return pr[ad[SECTOR_HALF_BIT] ? PROT_PHI : PROT_PLO];
            CMD_ONCE: return 1'b0;
            default: return |pr;
        endcase
    endfunction

    // Load, launch, serve the flash macro, then check flags; er = blank/verify/nc errors
    task automatic t(input logic [7:0] c, input logic [1:0] bs, input logic [15:0] ad,
            input logic [2:0] ix, input logic [4:0] md, input logic [2:0] pr,
            input logic [2:0] er);
        logic acc;
        logic pv;
        logic vr;
        logic [2:0] ops [$];
        logic [15:0] d;
        int n;
        int k;
        bw[0] = {c, 6'h00, bs};
        bw[1] = ad;
        for (k = 2; k < 6; k++) bw[k] = 16'($urandom);
        for (k = 0; k < 6; k++) begin
            wr_reg(OFS_IDX, 16'(k));
            wr_reg(OFS_BUF, bw[k]);
        end
        wr_reg(OFS_IDX, {13'h0000, ix});
        wr_reg(OFS_MODE, {11'h000, md});
        wr_reg(OFS_PROT, {13'h0000, pr});
        acc = f_acc(c, ix, bs, ad, md);
        pv = !acc && f_pv(c, bs, ad, pr);
        if (!(acc || pv)) begin
            if (c == CMD_ONCE) begin
                ops.push_back(FOP_BLANK);
                if (!er[2]) ops.push_back(FOP_PROG);
            end else begin
                ops.push_back(c == CMD_EBLK ? FOP_ERASE_BLK :
                    c == CMD_ESEC ? FOP_ERASE_SEC : FOP_ERASE_ALL);
            end
            if (c != CMD_ONCE || !er[2]) ops.push_back(FOP_VERIFY);
        end
        // Nothing else is written until completion
        wr_reg(OFS_STAT, 16'h00B0);
        n = 0;
        for (k = 0; k < 300; k++) begin
            @(posedge mclk);
            if (ccf === 1'b1) break;
            if (fl_req === 1'b1) begin
                `CHK(fl_op, (n < ops.size()) ? ops[n] : 3'h7)
                `CHK(fl_addr, bw[1])
                `CHK(fl_bsel, bs)
                if (c == CMD_ONCE && n > 0) `CHK(pf_inv, 1'b1)
                if (c == CMD_ONCE && n == 1) `CHK(fl_data, {bw[5], bw[4], bw[3], bw[2]})
                n++;
                // Random clock-enable gaps while the macro is busy
                repeat (1 + $urandom % 4) begin
                    ce <= 1'($urandom);
                    @(posedge mclk);
                end
                ce <= 1'b1;
                fl_done <= 1'b1;
                fl_err <= (fl_op == FOP_BLANK) ? er[2] :
                    (fl_op == FOP_VERIFY) ? er[1] : 1'($urandom);
                fl_ncerr <= (fl_op == FOP_VERIFY) ? er[0] : 1'b0;
                @(posedge mclk);
                fl_done <= 1'b0;
            end
        end
        `CHK(n, ops.size())
        `CHK(ccf, 1'b1)
        `CHK(pf_inv, 1'b0)
        if (c == CMD_ONCE && !(acc || pv) && er[2]) acc = 1'b1;
        vr = !(acc || pv);
        if (vr && (c == CMD_EALL || c == CMD_UNSEC) && er[1:0] == 2'h0) exp_sec = 1'b0;
        rd_reg(OFS_STAT, d);
        `CHK(d, {8'h00, 2'h2, acc, pv, 2'h0, vr && er[1:0] != 2'h0, vr && er[0]})
        rd_reg(OFS_SEC, d);
        `CHK(d, {15'h0000, exp_sec})
        `CHK(secure, exp_sec)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int unsigned rv;
        logic [15:0] d;
        logic [7:0] c;
        logic [1:0] bs;
        logic [15:0] ad;
        logic [2:0] ix;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        fl_done = 1'b0;
        fl_err = 1'b0;
        fl_ncerr = 1'b0;
        ce = 1'b1;
        reset_n = 1'b0;
        exp_sec = 1'b1;
        rv = $urandom(32'h08863B93);
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        `CHK(ccf, 1'b1)
        `CHK(secure, 1'b1)
        rd_reg(OFS_MODE, d);
        `CHK(d, 16'h001F)
        rd_reg(OFS_STAT, d);
        `CHK(d, 16'h0080)
        rd_reg(8'hFC, d);
        `CHK(d, 16'h0000)
        t(CMD_UNSEC, 2'h0, 16'h0000, 3'h0, 5'h1F, 3'h0, 3'h2);
        t(CMD_ONCE, 2'h0, 16'h0008, 3'h5, 5'h1F, 3'h0, 3'h0);
        t(CMD_ONCE, 2'h0, 16'h0007, 3'h4, 5'h1F, 3'h0, 3'h0);
        t(CMD_ONCE, 2'h0, 16'h0007, 3'h5, 5'h1F, 3'h0, 3'h4);
        t(CMD_ONCE, 2'h0, 16'h0007, 3'h5, 5'h1F, 3'h0, 3'h1);
        t(CMD_ONCE, 2'h0, 16'h0000, 3'h5, 5'h1E, 3'h0, 3'h0);
        t(CMD_ESEC, BSEL_PF, 16'h8000, 3'h1, 5'h1F, 3'h2, 3'h0);
        t(CMD_ESEC, BSEL_PF, 16'h8123, 3'h1, 5'h1F, 3'h1, 3'h0);
        t(CMD_ESEC, BSEL_PF, 16'h8120, 3'h1, 5'h1F, 3'h1, 3'h0);
        t(CMD_EBLK, BSEL_DF, 16'h0002, 3'h1, 5'h1F, 3'h4, 3'h0);
        t(CMD_EBLK, BSEL_DF, 16'h0003, 3'h1, 5'h1F, 3'h0, 3'h0);
        t(CMD_EBLK, 2'h2, 16'h0000, 3'h1, 5'h1F, 3'h0, 3'h0);
        t(CMD_EALL, 2'h0, 16'h0000, 3'h1, 5'h1F, 3'h0, 3'h0);
        t(CMD_EALL, 2'h0, 16'h0000, 3'h0, 5'h1D, 3'h0, 3'h0);
        t(CMD_EALL, 2'h0, 16'h0000, 3'h0, 5'h1F, 3'h4, 3'h0);
        t(CMD_EALL, 2'h0, 16'h0000, 3'h0, 5'h1F, 3'h0, 3'h0);
        for (int i = 0; i < 40; i++) begin
            c = CMD_ONCE + 8'($urandom % 5);
            bs = ($urandom % 3 == 0) ? 2'($urandom) : ($urandom % 2) ? BSEL_DF : BSEL_PF;
            ad = 16'($urandom);
            if ($urandom % 2) ad[2:0] = 3'h0;
            if (c == CMD_ONCE) ad = 16'($urandom % 10);
            ix = (c == CMD_ONCE) ? 3'h5 : (c == CMD_EBLK || c == CMD_ESEC) ? 3'h1 : 3'h0;
            if ($urandom % 5 == 0) ix = 3'($urandom);
            t(c, bs, ad, ix, ($urandom % 6 == 0) ? 5'($urandom) : 5'h1F,
                ($urandom % 4 == 0) ? 3'($urandom) : 3'h0,
                ($urandom % 3 == 0) ? 3'($urandom) : 3'h0);
        end
        end_sim();
    end
endmodule // tb_top
